// ---- clock_divider_fanout.sv ----
// Clock divider with eight gated output pairs and a bus slave for the disable mask.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module clock_divider_fanout
  import clkfan_pkg::*;
#(
  parameter int outputs = num_outputs
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic ref_clk_in,
  input wire logic [1:0] div_select_in,
  input wire logic bus_addr_strap_hi_in,
  input wire logic bus_addr_strap_lo_in,
  i2c_link_if.device link,
  output logic [outputs-1:0] clock_out_pair_p_out,
  output logic [outputs-1:0] clock_out_pair_n_out,
  output logic [outputs-1:0] clock_out_pair_oe_n_out,
  output logic [7:0] output_disable_mask_out
);
  import clkfan_pkg::*;

  if (outputs != 8) begin : g_bad_outputs
    $error("clock_divider_fanout serves exactly eight output pairs");
  end

  typedef enum {st_idle, st_addr, st_addr_ack, st_index, st_index_ack, st_wdata, st_wdata_ack,
    st_rdata, st_rdata_ack, st_ignore} slave_state_type;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Every pin other than rst_n_in and clk_en_in is foreign to clk_in, so each passes two flops before use.
  logic [5:0] sync_a;
  logic [5:0] sync_b;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync_a <= 6'h03; // Idle levels: selects, straps and reference low, bus lines high.
      sync_b <= 6'h03;
    end else if (clk_en_in) begin
      sync_a <= {ref_clk_in, div_select_in, bus_addr_strap_hi_in, link.scl, link.sda};
      sync_b <= sync_a;
    end
  end
  logic ref_s;
  logic [1:0] sel_s;
  logic strap_hi_s;
  logic scl_s;
  logic sda_s;
  logic strap_lo_a;
  logic strap_lo_s;
  assign {ref_s, sel_s, strap_hi_s, scl_s, sda_s} = sync_b;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      strap_lo_a <= 1'b0;
      strap_lo_s <= 1'b0;
    end else if (clk_en_in) begin
      strap_lo_a <= bus_addr_strap_lo_in;
      strap_lo_s <= strap_lo_a;
    end
  end

  // ----------------------------------------
  // Reference divider
  // ----------------------------------------
  // A free counter on reference rising edges; the tap picks the ratio.
  logic ref_d;
  logic [2:0] div_cnt;
  logic div_clk;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ref_d <= 1'b0;
      div_cnt <= 3'h0;
    end else if (clk_en_in) begin
      ref_d <= ref_s;
      if (ref_s && !ref_d) div_cnt <= div_cnt + 3'h1;
    end
  end
  always_comb begin
    unique case (sel_s)
      div_code_by1: div_clk = ref_s;
      div_code_by2: div_clk = div_cnt[0];
      div_code_by4: div_clk = div_cnt[1];
      div_code_by8: div_clk = div_cnt[2];
    endcase
  end

  // ----------------------------------------
  // Output pairs
  // ----------------------------------------
  logic [7:0] mask;
  genvar gi;
  generate
    for (gi = 0; gi < outputs; gi++) begin : g_pair
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          clock_out_pair_p_out[gi] <= 1'b0;
          clock_out_pair_n_out[gi] <= 1'b1;
          clock_out_pair_oe_n_out[gi] <= 1'b0;
        end else if (clk_en_in) begin
          clock_out_pair_p_out[gi] <= div_clk;
          clock_out_pair_n_out[gi] <= ~div_clk;
          clock_out_pair_oe_n_out[gi] <= mask[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Bus condition detection
  // ----------------------------------------
  logic scl_d;
  logic sda_d;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (clk_en_in) begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det = scl_s && scl_d && !sda_d && sda_s;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;

  // ----------------------------------------
  // Slave state machine
  // ----------------------------------------
  slave_state_type state;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic [7:0] index;
  logic sda_low;
  logic [6:0] my_addr;
  assign my_addr = {slave_addr_field_fixed, strap_hi_s, strap_lo_s};

  // Read data of the single register; other indices read as zero.
  function automatic logic [7:0] reg_read(input logic [7:0] idx, input logic [7:0] m);
    reg_read = (idx == reg_output_disable_mask) ? m : 8'h00;
  endfunction

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= st_idle;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      index <= 8'h00;
      sda_low <= 1'b0;
      mask <= output_disable_mask_reset;
    end else if (clk_en_in) begin
      if (start_det) begin
        state <= st_addr;
        bit_cnt <= 4'h0;
        sda_low <= 1'b0;
      end else if (stop_det) begin
        state <= st_idle;
        sda_low <= 1'b0;
      end else if (scl_rise) begin
        // Sample on the rising edge; data is stable while SCL is high.
        if (state inside {st_addr, st_index, st_wdata}) begin
          shift <= {shift[6:0], sda_s};
          bit_cnt <= bit_cnt + 4'h1;
        end else if (state == st_rdata_ack && sda_s) begin
          state <= st_ignore;
        end
      end else if (scl_fall) begin
        // Change SDA only after SCL falls, so it is steady over the high phase.
        unique case (state)
          st_addr: if (bit_cnt == 4'h8) begin
            if (shift[7:1] == my_addr) begin
              state <= st_addr_ack;
              sda_low <= 1'b1;
            end else begin
              state <= st_ignore;
            end
          end
          st_addr_ack: begin
            bit_cnt <= 4'h0;
            if (shift[0] == dir_read) begin
              state <= st_rdata;
              shift <= reg_read(index, mask);
              sda_low <= ~|(reg_read(index, mask) & 8'h80);
            end else begin
              state <= st_index;
              sda_low <= 1'b0;
            end
          end
          st_index: if (bit_cnt == 4'h8) begin
            state <= st_index_ack;
            index <= shift;
            sda_low <= 1'b1;
          end
          st_index_ack: begin
            state <= st_wdata;
            bit_cnt <= 4'h0;
            sda_low <= 1'b0;
          end
          st_wdata: if (bit_cnt == 4'h8) begin
            state <= st_wdata_ack;
            if (index == reg_output_disable_mask) mask <= shift;
            sda_low <= 1'b1;
          end
          st_wdata_ack: begin
            // Further bytes go to the following index.
            state <= st_wdata;
            index <= index + 8'h01;
            bit_cnt <= 4'h0;
            sda_low <= 1'b0;
          end
          st_rdata: begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'h7) begin
              state <= st_rdata_ack;
              sda_low <= 1'b0;
            end else begin
              shift <= {shift[6:0], 1'b0};
              sda_low <= ~shift[6];
            end
          end
          st_rdata_ack: begin
            state <= st_rdata;
            index <= index + 8'h01;
            bit_cnt <= 4'h0;
            shift <= reg_read(index + 8'h01, mask);
            sda_low <= ~|(reg_read(index + 8'h01, mask) & 8'h80);
          end
          st_idle, st_ignore: sda_low <= 1'b0;
        endcase
      end
    end
  end

  // Open-drain: only ever drive low, never touch SCL.
  assign link.sda_dev_out = 1'b0;
  assign link.sda_dev_oe_n = ~sda_low;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) output_disable_mask_out <= output_disable_mask_reset;
    else if (clk_en_in) output_disable_mask_out <= mask;
  end
endmodule

// ---- clkfan_pkg.sv ----
// Package with shared constants for the clock fanout device and its bus controller.
package clkfan_pkg;
  // ----------------------------------------
  // Bus addressing, mask reset and output count
  // ----------------------------------------
  localparam logic [4:0] slave_addr_field_fixed = 5'h1a;
  localparam logic [7:0] reg_output_disable_mask = 8'h00;
  localparam logic [7:0] output_disable_mask_reset = 8'h00;
  localparam int num_outputs = 8;
  localparam logic dir_read = 1'b1;
  localparam logic dir_write = 1'b0;
  // ----------------------------------------
  // Divider codes and timing
  // ----------------------------------------
  localparam logic [1:0] div_code_by1 = 2'h0;
  localparam logic [1:0] div_code_by2 = 2'h1;
  localparam logic [1:0] div_code_by4 = 2'h2;
  localparam logic [1:0] div_code_by8 = 2'h3;
  localparam int clk_period_ns = 10;
  localparam int scl_quarter_ns = 2500;
  localparam int scl_quarter_cycles = scl_quarter_ns / clk_period_ns;
  // Controller command register offsets.
  localparam logic [3:0] cmd_addr_ctrl = 4'h0;
  localparam logic [3:0] cmd_addr_data = 4'h1;
  localparam logic [3:0] cmd_addr_status = 4'h2;
  localparam logic [3:0] cmd_addr_slave = 4'h3;
endpackage

// ---- i2c_link_if.sv ----
// Interface joining the bus controller and the clock fanout device.
`timescale 1ns/1ps
interface i2c_link_if;
  logic scl_out;
  logic scl_oe_n;
  logic sda_ctrl_out;
  logic sda_ctrl_oe_n;
  logic sda_dev_out;
  logic sda_dev_oe_n;
  logic scl;
  logic sda;
  // Wired-AND with pull-up: any enabled low driver wins.
  assign scl = ~(~scl_oe_n & ~scl_out);
  assign sda = ~((~sda_ctrl_oe_n & ~sda_ctrl_out) | (~sda_dev_oe_n & ~sda_dev_out));
  modport device (input scl, input sda, output sda_dev_out, output sda_dev_oe_n);
  modport controller (input scl, input sda, output scl_out, output scl_oe_n,
                      output sda_ctrl_out, output sda_ctrl_oe_n);
endinterface

// ---- i2c_bus_controller.sv ----
// Bus controller that performs single-register writes and reads on the device.
`timescale 1ns/1ps
module i2c_bus_controller
  import clkfan_pkg::*;
#(
  parameter int quarter_cycles = scl_quarter_cycles
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  i2c_link_if.controller link
);
  import clkfan_pkg::*;

  if (quarter_cycles < 1 || quarter_cycles > 65535) begin : g_bad_quarter
    $error("quarter_cycles out of range");
  end

  typedef enum {st_idle, st_start, st_bit, st_stop, st_rstart} ctl_state_type;

  // ----------------------------------------
  // Command registers
  // ----------------------------------------
  // ctrl: bit0 go write, bit1 go read. data: write byte / read result.
  logic [7:0] index;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic [6:0] slave;
  logic busy;
  logic nack;
  logic go_wr;
  logic go_rd;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      index <= 8'h00;
      wbyte <= 8'h00;
      slave <= {slave_addr_field_fixed, 2'h0};
      go_wr <= 1'b0;
      go_rd <= 1'b0;
    end else if (clk_en_in) begin
      go_wr <= wr_in && addr_in == cmd_addr_ctrl && wdata_in[0] && !busy;
      go_rd <= wr_in && addr_in == cmd_addr_ctrl && wdata_in[1] && !busy;
      if (wr_in && addr_in == cmd_addr_data) wbyte <= wdata_in;
      if (wr_in && addr_in == cmd_addr_slave) slave <= wdata_in[6:0];
      if (wr_in && addr_in == cmd_addr_ctrl) index <= {4'h0, wdata_in[7:4]};
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) rdata_out <= 8'h00;
    else if (clk_en_in && rd_in) begin
      unique case (addr_in)
        cmd_addr_data: rdata_out <= rbyte;
        cmd_addr_status: rdata_out <= {6'h00, nack, busy};
        cmd_addr_slave: rdata_out <= {1'b0, slave};
        default: rdata_out <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Bit engine
  // ----------------------------------------
  // Bytes: 0 addr+W, 1 index, 2 data (write) | 0 addr+W,1 index,RS,2 addr+R,3 read.
  ctl_state_type state;
  logic [15:0] tick;
  logic [1:0] phase;
  logic [3:0] bitn;
  logic [1:0] byten;
  logic is_read;
  logic [7:0] tx;
  logic scl_lo;
  logic sda_lo;
  logic sda_s1;
  logic sda_s2;
  logic tick_done;
  assign tick_done = tick == quarter_cycles[15:0] - 16'h1;

  // The byte sent in each slot of the sequence.
  function automatic logic [7:0] byte_for(input logic [1:0] n, input logic rd);
    byte_for = (n == 2'h0) ? {slave, dir_write} : (n == 2'h1) ? index :
      (rd ? {slave, dir_read} : wbyte);
  endfunction

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else if (clk_en_in) begin
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= st_idle;
      tick <= 16'h0;
      phase <= 2'h0;
      bitn <= 4'h0;
      byten <= 2'h0;
      is_read <= 1'b0;
      tx <= 8'h00;
      scl_lo <= 1'b0;
      sda_lo <= 1'b0;
      busy <= 1'b0;
      nack <= 1'b0;
      rbyte <= 8'h00;
    end else if (clk_en_in) begin
      if (state == st_idle) begin
        tick <= 16'h0;
        phase <= 2'h0;
        if (go_wr || go_rd) begin
          state <= st_start;
          is_read <= go_rd;
          busy <= 1'b1;
          nack <= 1'b0;
          byten <= 2'h0;
        end
      end else if (!tick_done) begin
        tick <= tick + 16'h1;
      end else begin
        tick <= 16'h0;
        phase <= phase + 2'h1;
        unique case (state)
          st_start, st_rstart: if (phase == 2'h1) begin
            sda_lo <= 1'b1;
          end else if (phase == 2'h3) begin
            scl_lo <= 1'b1;
            state <= st_bit;
            bitn <= 4'h0;
            tx <= byte_for(byten, is_read);
          end else if (phase == 2'h0) begin
            scl_lo <= 1'b0;
          end
          st_bit: unique case (phase)
            2'h0: begin
              // Data set while SCL low; the ACK slot is always released.
              if (bitn < 4'h8) sda_lo <= ~(tx[7] | (is_read && byten == 2'h3));
              else sda_lo <= 1'b0;
            end
            2'h1: scl_lo <= 1'b0;
            2'h2: begin
              if (bitn < 4'h8) begin
                rbyte <= {rbyte[6:0], sda_s2};
              end else if (!(is_read && byten == 2'h3) && sda_s2) begin
                nack <= 1'b1;
              end
            end
            2'h3: begin
              scl_lo <= 1'b1;
              tx <= {tx[6:0], 1'b0};
              bitn <= bitn + 4'h1;
              if (bitn == 4'h8) begin
                bitn <= 4'h0;
                byten <= byten + 2'h1;
                tx <= byte_for(byten + 2'h1, is_read);
                if (nack || (!is_read && byten == 2'h2) || byten == 2'h3) state <= st_stop;
                else if (is_read && byten == 2'h1) state <= st_rstart;
              end
            end
          endcase
          st_idle: phase <= 2'h0;
          st_stop: unique case (phase)
            2'h0: sda_lo <= 1'b1;
            2'h1: scl_lo <= 1'b0;
            2'h2: sda_lo <= 1'b0;
            2'h3: begin
              state <= st_idle;
              busy <= 1'b0;
            end
          endcase
        endcase
        if (state == st_rstart && phase == 2'h0) sda_lo <= 1'b0;
      end
    end
  end

  assign link.scl_out = 1'b0;
  assign link.scl_oe_n = ~scl_lo;
  assign link.sda_ctrl_out = 1'b0;
  assign link.sda_ctrl_oe_n = ~sda_lo;
endmodule

// ---- clkfan_link_props.sv ----
// Checker of the bus wires between the controller and the clock fanout device.
`timescale 1ns/1ps
module clkfan_link_props (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_ctrl_out,
  input wire logic sda_ctrl_oe_n,
  input wire logic sda_dev_out,
  input wire logic sda_dev_oe_n,
  input wire logic scl,
  input wire logic sda
);
  // ----------------------------------------
  // Wire checks
  // ----------------------------------------
  // All checks share the system clock and its reset.
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // Only pulling low is allowed, so no party can fight the pull-up.
  dev_open_drain_a: assert property (sda_dev_out == 1'b0)
    else $error("device drives SDA high");
  ctrl_open_drain_a: assert property (scl_out == 1'b0 && sda_ctrl_out == 1'b0)
    else $error("controller drives a line high");
  // The device may move SDA only in the low phase of SCL.
  dev_sda_steady_a: assert property (scl && $past(scl) |-> $stable(sda_dev_oe_n))
    else $error("device moved SDA while SCL high");
  dev_pull_timing_a: assert property ($fell(sda_dev_oe_n) |-> !scl)
    else $error("device pulled SDA while SCL high");
  dev_release_timing_a: assert property ($rose(sda_dev_oe_n) |-> !scl)
    else $error("device released SDA while SCL high");
  // A pulled bit stays low across the whole high phase of at least 8 cycles.
  dev_ack_hold_a: assert property ($rose(scl) && !sda_dev_oe_n |-> !sda_dev_oe_n [*8])
    else $error("device let go of SDA inside the high phase");
  // After a stop the device stays off the bus for at least the 4 cycles from the stop onward.
  stop_release_a: assert property (scl && $past(scl) && $rose(sda) |-> sda_dev_oe_n [*4])
    else $error("device holds SDA after a stop");
  scl_low_bound_a: assert property ($fell(scl) |-> ##[1:40] scl)
    else $error("SCL stuck low");
endmodule

// ---- clock_divider_fanout_output_enable_tb.sv ----
// Self-checking bench for the clock fanout device and its bus controller.
`timescale 1ns/1ps
module clock_divider_fanout_output_enable_tb;
  import clkfan_pkg::*;
  logic clk_in, rst_n_in, ref_clk, strap_hi, strap_lo, wr, rd, ref_q, p_q;
  logic [1:0] div_select;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, p_out, n_out, oe_n, mask_out, st, rv;
  logic [1:0] codes [4] = '{2'h3, 2'h0, 2'h2, 2'h1};
  int n_errors = 0, check_count = 0, cycles = 0, model_mask = 0, ref_rises = 0, p_rises = 0;
  int r0, p0;
  logic [1:0] s;

  i2c_link_if link();
  clock_divider_fanout #(.outputs(num_outputs)) clock_divider_fanout_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1), .ref_clk_in(ref_clk),
    .div_select_in(div_select), .bus_addr_strap_hi_in(strap_hi),
    .bus_addr_strap_lo_in(strap_lo), .link(link.device), .clock_out_pair_p_out(p_out),
    .clock_out_pair_n_out(n_out), .clock_out_pair_oe_n_out(oe_n),
    .output_disable_mask_out(mask_out));
  i2c_bus_controller #(.quarter_cycles(5)) i2c_bus_controller_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .link(link.controller));
  clkfan_link_props props (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_out(link.scl_out), .scl_oe_n(link.scl_oe_n),
    .sda_ctrl_out(link.sda_ctrl_out), .sda_ctrl_oe_n(link.sda_ctrl_oe_n),
    .sda_dev_out(link.sda_dev_out), .sda_dev_oe_n(link.sda_dev_oe_n),
    .scl(link.scl), .sda(link.sda));

  // ----------------------------------------
  // Clocks, edge counters and time limit
  // ----------------------------------------
  // System clock of 10 ns period.
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Reference of 74 ns period; the odd offset keeps its edges off the system edges.
  initial begin
    ref_clk = 1'b0;
    #3.5;
    forever #37 ref_clk = ~ref_clk;
  end
  // Rising edges are counted on the system clock so both counts share one time base.
  always @(posedge clk_in) begin
    ref_q <= ref_clk;
    p_q <= p_out[0];
    if (ref_clk && !ref_q) ref_rises <= ref_rises + 1;
    if (p_out[0] === 1'b1 && p_q === 1'b0) p_rises <= p_rises + 1;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      $display("wrong value at %0t: run did not finish in time", $time);
      finish_test();
    end
  end

  // ----------------------------------------
  // Compare, command bus and transfer tasks
  // ----------------------------------------
  // Compare of one byte-wide result.
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Edge counts may differ by one because the window cuts a period at each end.
  task automatic check_near(input int got, input int exp, input string what);
    check_count++;
    if (got < exp - 1 || got > exp + 1) begin
      n_errors++;
      $display("wrong value at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask
  // Each access waits for an edge first, so two strobes never land in one time step.
  task automatic cmd_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic cmd_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Runs one bus transaction and polls the busy flag, which rises one cycle after go_wr or go_rd.
  task automatic xfer(input logic [6:0] slave, input logic [1:0] go, output logic [7:0] sts);
    int tries;
    cmd_wr(cmd_addr_slave, {1'b0, slave});
    cmd_wr(cmd_addr_ctrl, {4'h0, 2'b00, go});
    repeat (3) @(posedge clk_in);
    tries = 0;
    do begin
      cmd_rd(cmd_addr_status, sts);
      tries++;
    end while (sts[0] !== 1'b0 && tries < 4000);
    if (tries >= 4000) begin
      n_errors++;
      $display("wrong value at %0t: controller stays busy", $time);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n_in = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    strap_hi = 1'b0;
    strap_lo = 1'b0;
    div_select = 2'h0;
    void'($urandom(73640));
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    #1;
    check8(mask_out, 8'h00, "mask after reset");
    check8(oe_n, 8'h00, "enables after reset");
    $display("test reset done");
    // Random straps and masks, with all-ones first as the boundary case.
    for (int i = 0; i < 4; i++) begin
      s = 2'($urandom_range(3));
      @(posedge clk_in);
      strap_hi <= s[1];
      strap_lo <= s[0];
      repeat (4) @(posedge clk_in);
      model_mask = (i == 0) ? 8'hff : (i == 3) ? 8'h00 : int'($urandom_range(255));
      cmd_wr(cmd_addr_data, 8'(model_mask));
      xfer({slave_addr_field_fixed, s}, 2'b01, st);
      check8({7'h0, st[1]}, 8'h00, "write acknowledged");
      check8(mask_out, 8'(model_mask), "mask after write");
      check8(oe_n, 8'(model_mask), "pair enables");
      cmd_wr(cmd_addr_data, 8'h5a);
      xfer({slave_addr_field_fixed, s}, 2'b10, st);
      cmd_rd(cmd_addr_data, rv);
      check8(rv, 8'(model_mask), "read back");
      check8({6'h0, st[1:0]}, 8'h00, "read finished with ack");
      cmd_rd(cmd_addr_slave, rv);
      check8(rv, {1'b0, slave_addr_field_fixed, s}, "slave register");
    end
    $display("test write and read done");
    // A foreign address must be refused and leave the mask alone.
    for (int j = 0; j < 2; j++) begin
      cmd_wr(cmd_addr_data, 8'(~model_mask));
      xfer(j == 0 ? {slave_addr_field_fixed, ~s} : {slave_addr_field_fixed ^ 5'h01, s},
           2'b01, st);
      check8({7'h0, st[1]}, 8'h01, "foreign address refused");
      check8(mask_out, 8'(model_mask), "mask kept");
      check8(oe_n, 8'(model_mask), "enables kept");
    end
    $display("test foreign address done");
    // Ratio changes are applied mid-run, in a shuffled order of all four codes.
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_in);
      div_select <= codes[k];
      repeat (20) @(posedge clk_in);
      r0 = ref_rises;
      p0 = p_rises;
      repeat (800) @(posedge clk_in);
      #1;
      check_near(p_rises - p0, (ref_rises - r0) >> codes[k], "output edges");
      check8(n_out, ~p_out, "complement outputs");
      check8(p_out, {8{p_out[0]}}, "pairs in step");
    end
    $display("test divider done");
    finish_test();
  end
endmodule
